// ### hw/mqw_params.svh
// Purpose: Offsets, field positions and reset values for the write port select block
// Assumes: Included by bare name; 32-bit AXI4-Lite register bus, byte addresses
// Notes: Each register takes one aligned word, unused bits read as zero
// How it works
// RQ1 - Queue address is captured only on edges where the select strobe is high
// RQ2 - Writer pulses the select strobe only while changing queues, never held high
// RQ3 - Writer never raises select strobe and flag-bus strobe in one cycle
// RQ4 - Select strobe is ignored until programming done output is low
// RQ5 - Each write edge with write enable stores the input word in selected queue; code drops the word when that queue is full
// RQ6 - Direct mode: flag-bus strobe edge picks which device drives the flag bus
// RQ7 - Polled mode: flag bus steps each write edge, sync pulse on write clock
// RQ8 - Almost-full bus, almost-full flag and full flag change only on write edges
// RQ9 - Flag expansion out and in are timed on the write clock
// RQ10 - Writer supplies a continuous free-running write clock
// RQ11 - New queue takes data from the second edge after its selection edge
// RQ12 - Selection edge and next edge still write the previous queue
// RQ13 - Low three select bits pick a queue, high three must match device id
// RQ14 - Flag-bus device choice ignores low three select bits
// RQ15 - Write queue selection is held until the next strobed select edge
`ifndef MQW_PARAMS_SVH
`define MQW_PARAMS_SVH
`define MQW_ADDR_W 8
`define MQW_REG_CTRL 8'h00
`define MQW_REG_STATE 8'h04
`define MQW_REG_IRQ_STAT 8'h08
`define MQW_REG_IRQ_MASK 8'h0c
`define MQW_REG_FLAGS 8'h10
`define MQW_CTRL_POLLED 0
`define MQW_CTRL_ID_LSB 1
`define MQW_CTRL_RESET 4'h0
`define MQW_ST_VALID 3
`define MQW_ST_DRIVE 4
`define MQW_ST_DONE 5
`define MQW_FLAGS_AF_LSB 8
`define MQW_EV_REFUSED 0
`define MQW_EV_OVERRUN 1
`define MQW_EV_CONTEND 2
`define MQW_EV_N 3
`define MQW_RESP_OKAY 2'h0
`define MQW_RESP_SLVERR 2'h2
`endif

// ### hw/mqw_pkg.sv
// Purpose: Types for the write port select block
// Assumes: Constants live in mqw_params.svh
// Notes: Used by package-qualified names only
package mqw_pkg;
  typedef enum logic {MQW_DIRECT, MQW_POLLED} mqw_flag_mode_t;
  typedef enum logic {MQW_SEL_IDLE, MQW_SEL_PENDING} mqw_sel_state_t;
endpackage : mqw_pkg

// ### hw/mqw_queue_bank.sv
// Purpose: Eight flip-flop queues with per-queue full and almost-full status
// Assumes: DEPTH is a power of two
// Notes: Writes to a full queue and reads of an empty one are dropped
`timescale 1ns/10ps
`default_nettype none
module mqw_queue_bank #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4,
  parameter int AF_MARGIN = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [2:0] wr_queue,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [2:0] rd_queue,
  output logic [WIDTH-1:0] rd_data,
  // Status
  output logic [7:0] full_vec,
  output logic [7:0] almost_full_vec
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [8*DEPTH];
  logic [PW-1:0] wptr [8];
  logic [PW-1:0] rptr [8];
  logic [PW:0] cnt [8];
  logic do_wr;
  logic do_rd;

  assign do_wr = wr_en && !full_vec[wr_queue];
  assign do_rd = rd_en && (cnt[rd_queue] != '0);

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[{wr_queue, wptr[wr_queue]}] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (do_rd) begin
      rd_data <= mem[{rd_queue, rptr[rd_queue]}];
    end
  end

  always_ff @(posedge clk) begin
    for (int q = 0; q < 8; q++) begin
      if (!rst_n) begin
        wptr[q] <= '0;
        rptr[q] <= '0;
        cnt[q] <= '0;
      end else begin
        if (do_wr && wr_queue == 3'(q)) begin
          wptr[q] <= wptr[q] + PW'(1);
        end
        if (do_rd && rd_queue == 3'(q)) begin
          rptr[q] <= rptr[q] + PW'(1);
        end
        cnt[q] <= cnt[q] + {{PW{1'b0}}, do_wr && wr_queue == 3'(q)}
          - {{PW{1'b0}}, do_rd && rd_queue == 3'(q)};
      end
    end
  end

  always_comb begin
    for (int q = 0; q < 8; q++) begin
      full_vec[q] = (cnt[q] == (PW+1)'(DEPTH));
      almost_full_vec[q] = (cnt[q] >= (PW+1)'(DEPTH - AF_MARGIN));
    end
  end
endmodule : mqw_queue_bank
`default_nettype wire

// ### hw/mqw_write_port_select.sv
// Purpose: Write-side queue select, write steering and almost-full flag bus control
// Assumes: aclk is the free-running write clock; writer logic runs on it
// Notes: Registers over AXI4-Lite; one level interrupt from sticky events
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "mqw_params.svh"
module mqw_write_port_select #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4,
  parameter int AF_MARGIN = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [`MQW_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MQW_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Writer port
  input wire logic queue_select_strobe,
  input wire logic [5:0] write_select_bus,
  input wire logic flag_bus_strobe,
  input wire logic write_enable_n,
  input wire logic [WIDTH-1:0] data_in,
  // Configuration
  input wire logic program_ready,
  output logic program_done_out_n,
  // Read side drain
  input wire logic read_en,
  input wire logic [2:0] read_queue,
  output logic [WIDTH-1:0] read_data,
  // Flags and expansion
  output logic full_flag,
  output logic almost_full_flag,
  output logic [7:0] almost_full_flag_bus,
  output logic almost_full_flag_bus_oe,
  output logic flag_bus_sync,
  output logic flag_expansion_out,
  input wire logic flag_expansion_in,
  // Interrupt
  output logic irq
);
  logic [3:0] ctrl_reg, w_strb_reg;
  logic [`MQW_EV_N-1:0] irq_stat_reg, irq_mask_reg, event_vec;
  mqw_pkg::mqw_flag_mode_t flag_mode;
  mqw_pkg::mqw_sel_state_t sel_state_reg;
  logic [2:0] dev_id, pend_queue_reg, wr_queue_reg, poll_cnt_reg;
  logic pend_hit_reg, wr_valid_reg, sel_ok, wr_go, owner_reg, fx_in_reg;
  logic aw_hold_reg, w_hold_reg, do_reg_wr;
  logic [7:0] full_vec, af_vec;
  logic [`MQW_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg, rd_mux;
  function automatic logic reg_known(input logic [`MQW_ADDR_W-1:0] a);
    reg_known = (a == `MQW_REG_CTRL) || (a == `MQW_REG_STATE) || (a == `MQW_REG_IRQ_STAT)
      || (a == `MQW_REG_IRQ_MASK) || (a == `MQW_REG_FLAGS);
  endfunction : reg_known

  assign flag_mode = ctrl_reg[`MQW_CTRL_POLLED] ? mqw_pkg::MQW_POLLED : mqw_pkg::MQW_DIRECT;
  assign dev_id = ctrl_reg[`MQW_CTRL_ID_LSB +: 3];
  // Done output goes low once setup logic reports programming complete
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_done_out_n <= 1'b1;
    end else begin
      program_done_out_n <= !program_ready;
    end
  end
  // RQ4 lockout before done
  assign sel_ok = queue_select_strobe && !program_done_out_n;
  // RQ12 old queue kept two edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_state_reg <= mqw_pkg::MQW_SEL_IDLE;
      pend_queue_reg <= 3'h0;
      pend_hit_reg <= 1'b0;
      wr_queue_reg <= 3'h0;
      wr_valid_reg <= 1'b0;
    end else begin
      // RQ1 strobed capture
      if (sel_ok) begin
        pend_queue_reg <= write_select_bus[2:0];
        // RQ13 device id match
        pend_hit_reg <= (write_select_bus[5:3] == dev_id);
      end
      // RQ15 held until strobe
      case (sel_state_reg)
        mqw_pkg::MQW_SEL_IDLE: begin
          if (sel_ok) begin
            sel_state_reg <= mqw_pkg::MQW_SEL_PENDING;
          end
        end
        mqw_pkg::MQW_SEL_PENDING: begin
          // RQ11 commit one edge later
          wr_queue_reg <= pend_queue_reg;
          wr_valid_reg <= pend_hit_reg;
          sel_state_reg <= sel_ok ? mqw_pkg::MQW_SEL_PENDING : mqw_pkg::MQW_SEL_IDLE;
        end
        default: begin
          sel_state_reg <= mqw_pkg::MQW_SEL_IDLE;
        end
      endcase
    end
  end

  // RQ5 write steering
  assign wr_go = !write_enable_n && wr_valid_reg;

  mqw_queue_bank #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AF_MARGIN(AF_MARGIN)
  ) u_bank (
    .clk(aclk),
    .rst_n(aresetn),
    .wr_en(wr_go),
    .wr_queue(wr_queue_reg),
    .wr_data(data_in),
    .rd_en(read_en),
    .rd_queue(read_queue),
    .rd_data(read_data),
    .full_vec(full_vec),
    .almost_full_vec(af_vec)
  );

  // RQ8 flags on write edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_flag <= 1'b0;
      almost_full_flag <= 1'b0;
      almost_full_flag_bus <= 8'h00;
    end else begin
      full_flag <= full_vec[wr_queue_reg];
      almost_full_flag <= af_vec[wr_queue_reg];
      almost_full_flag_bus <= af_vec;
    end
  end

  // Flag bus ownership, polling and expansion; enables are registered so edges line up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      owner_reg <= 1'b0;
      poll_cnt_reg <= 3'h0;
      flag_bus_sync <= 1'b0;
      almost_full_flag_bus_oe <= 1'b0;
      flag_expansion_out <= 1'b0;
      fx_in_reg <= 1'b0;
    end else begin
      // RQ6 direct device choice
      if (flag_bus_strobe) begin
        // RQ14 upper bits only
        owner_reg <= (write_select_bus[5:3] == dev_id);
      end
      // RQ7 polled stepping and sync
      poll_cnt_reg <= poll_cnt_reg + 3'h1;
      flag_bus_sync <= (flag_mode == mqw_pkg::MQW_POLLED) && (poll_cnt_reg == 3'h7);
      if (flag_mode == mqw_pkg::MQW_POLLED) begin
        almost_full_flag_bus_oe <= ((poll_cnt_reg + 3'h1) == dev_id);
      end else begin
        almost_full_flag_bus_oe <= flag_bus_strobe ? (write_select_bus[5:3] == dev_id) : owner_reg;
      end
      // RQ9 expansion on write clock
      flag_expansion_out <= almost_full_flag_bus_oe;
      fx_in_reg <= flag_expansion_in;
    end
  end

  assign event_vec[`MQW_EV_REFUSED] = queue_select_strobe && program_done_out_n;
  assign event_vec[`MQW_EV_OVERRUN] = wr_go && full_vec[wr_queue_reg];
  assign event_vec[`MQW_EV_CONTEND] = fx_in_reg && almost_full_flag_bus_oe;

  // AXI write: address and data are held apart, then applied together
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign do_reg_wr = aw_hold_reg && w_hold_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MQW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_reg_wr) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_known(aw_addr_reg) ? `MQW_RESP_OKAY : `MQW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `MQW_CTRL_RESET;
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
    end else begin
      if (do_reg_wr && w_strb_reg[0] && aw_addr_reg == `MQW_REG_CTRL) begin
        ctrl_reg <= w_data_reg[3:0];
      end
      if (do_reg_wr && w_strb_reg[0] && aw_addr_reg == `MQW_REG_IRQ_MASK) begin
        irq_mask_reg <= w_data_reg[`MQW_EV_N-1:0];
      end
      if (do_reg_wr && w_strb_reg[0] && aw_addr_reg == `MQW_REG_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~w_data_reg[`MQW_EV_N-1:0]) | event_vec;
      end else begin
        irq_stat_reg <= irq_stat_reg | event_vec;
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `MQW_REG_CTRL: rd_mux[3:0] = ctrl_reg;
      `MQW_REG_STATE: begin
        rd_mux[2:0] = wr_queue_reg;
        rd_mux[`MQW_ST_VALID] = wr_valid_reg;
        rd_mux[`MQW_ST_DRIVE] = almost_full_flag_bus_oe;
        rd_mux[`MQW_ST_DONE] = !program_done_out_n;
      end
      `MQW_REG_IRQ_STAT: rd_mux[`MQW_EV_N-1:0] = irq_stat_reg;
      `MQW_REG_IRQ_MASK: rd_mux[`MQW_EV_N-1:0] = irq_mask_reg;
      `MQW_REG_FLAGS: begin
        rd_mux[7:0] = full_vec;
        rd_mux[`MQW_FLAGS_AF_LSB +: 8] = af_vec;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // AXI read answers one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MQW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= reg_known(s_axi_araddr) ? `MQW_RESP_OKAY : `MQW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_select_then_quiet;
    sel_ok ##1 !sel_ok;
  endsequence
  sequence s_poll_wrap;
    (flag_mode == mqw_pkg::MQW_POLLED) && (poll_cnt_reg == 3'h7) ##1
      (flag_mode == mqw_pkg::MQW_POLLED);
  endsequence
  property p_sel_capture;
    sel_ok |=> pend_queue_reg == $past(write_select_bus[2:0]);
  endproperty
  a_sel_capture: assert property (p_sel_capture) else $error("queue address not captured"); // RQ1
  property p_id_decode;
    sel_ok |=> pend_hit_reg == ($past(write_select_bus[5:3]) == $past(dev_id));
  endproperty
  a_id_decode: assert property (p_id_decode) else $error("device id decode wrong"); // RQ13
  property p_lockout;
    queue_select_strobe && program_done_out_n && sel_state_reg == mqw_pkg::MQW_SEL_IDLE
      |=> sel_state_reg == mqw_pkg::MQW_SEL_IDLE && $stable(pend_queue_reg);
  endproperty
  a_lockout: assert property (p_lockout) else $error("select taken before done"); // RQ4
  property p_old_queue;
    sel_ok && sel_state_reg == mqw_pkg::MQW_SEL_IDLE |=> $stable(wr_queue_reg);
  endproperty
  a_old_queue: assert property (p_old_queue) else $error("queue switched too early"); // RQ12
  property p_new_queue;
    s_select_then_quiet |=> wr_queue_reg == $past(write_select_bus[2:0], 2);
  endproperty
  a_new_queue: assert property (p_new_queue) else $error("new queue not active"); // RQ11
  property p_hold;
    !sel_ok && sel_state_reg == mqw_pkg::MQW_SEL_IDLE
      |=> $stable(wr_queue_reg) && $stable(wr_valid_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("selection changed without strobe"); // RQ15
  property p_write_go;
    wr_go && !full_vec[wr_queue_reg] && !(read_en && read_queue == wr_queue_reg)
      |=> u_bank.cnt[$past(wr_queue_reg)] == $past(u_bank.cnt[wr_queue_reg]) + 1'b1;
  endproperty
  a_write_go: assert property (p_write_go) else $error("write word not stored"); // RQ5
  property p_direct_owner;
    flag_mode == mqw_pkg::MQW_DIRECT && flag_bus_strobe
      |=> almost_full_flag_bus_oe == ($past(write_select_bus[5:3]) == $past(dev_id));
  endproperty
  a_direct_owner: assert property (p_direct_owner) else $error("flag bus owner wrong"); // RQ6
  property p_poll_sync;
    s_poll_wrap |-> flag_bus_sync && poll_cnt_reg == 3'h0;
  endproperty
  a_poll_sync: assert property (p_poll_sync) else $error("poll sync misplaced"); // RQ7
  property p_flags;
    1'b1 |=> full_flag == $past(full_vec[wr_queue_reg]) && almost_full_flag_bus == $past(af_vec);
  endproperty
  a_flags: assert property (p_flags) else $error("flags not on write edge"); // RQ8
  property p_fxo;
    1'b1 |=> flag_expansion_out == $past(almost_full_flag_bus_oe);
  endproperty
  a_fxo: assert property (p_fxo) else $error("expansion out misaligned"); // RQ9
endmodule : mqw_write_port_select
`default_nettype wire

// ### verification/mqw_writer_model.sv
// Purpose: Upstream writer model for the select, flag strobe and data pins
// Assumes: Shares the free-running write clock with the block
// Notes: Idle buses show the inverse of their last value, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module mqw_writer_model (
  // Clock and status
  input wire logic aclk,
  input wire logic program_done_out_n,
  // Writer pins
  output logic queue_select_strobe,
  output logic [5:0] write_select_bus,
  output logic flag_bus_strobe,
  output logic write_enable_n,
  output logic [35:0] data_in
);
  // Set only by a scenario that selects before setup is done on purpose
  bit allow_early = 1'b0;
  initial begin
    queue_select_strobe = 1'b0;
    write_select_bus = 6'h00;
    flag_bus_strobe = 1'b0;
    write_enable_n = 1'b1;
    data_in = 36'h0;
  end
  // One cycle of writer activity, launched just after the next edge
  task automatic step(input logic s, input logic [5:0] a, input logic f,
                      input logic wn, input logic [35:0] d);
    logic se;
    @(posedge aclk);
    se = s & (allow_early | ~program_done_out_n);
    queue_select_strobe <= se;
    flag_bus_strobe <= f & ~se;
    write_select_bus <= (se | f) ? a : ~write_select_bus;
    write_enable_n <= wn;
    data_in <= wn ? ~data_in : d;
  endtask : step
endmodule : mqw_writer_model
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for the write port select block
// Assumes: Writer model drives the writer pins; bench drives AXI and drain
// Notes: Tiny queues (DEPTH 4) so full and almost-full are reached quickly
`timescale 1ns/10ps
`default_nettype none
`include "mqw_params.svh"
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, queue_select_strobe, flag_bus_strobe, write_enable_n;
  logic program_ready, program_done_out_n, read_en, full_flag, almost_full_flag;
  logic almost_full_flag_bus_oe, flag_bus_sync, flag_expansion_out, flag_expansion_in;
  logic irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, almost_full_flag_bus;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [5:0] write_select_bus;
  logic [35:0] data_in, read_data;
  logic [2:0] read_queue;
  logic [15:0] sv, ov;
  int mismatches, checked, cyc;

  mqw_write_port_select #(.WIDTH(36), .DEPTH(4), .AF_MARGIN(1)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .queue_select_strobe,
    .write_select_bus, .flag_bus_strobe, .write_enable_n, .data_in, .program_ready,
    .program_done_out_n, .read_en, .read_queue, .read_data, .full_flag,
    .almost_full_flag, .almost_full_flag_bus, .almost_full_flag_bus_oe,
    .flag_bus_sync, .flag_expansion_out, .flag_expansion_in, .irq);
  mqw_writer_model wr (.aclk, .program_done_out_n, .queue_select_strobe,
    .write_select_bus, .flag_bus_strobe, .write_enable_n, .data_in);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : reg_rd

  task automatic drain(input logic [2:0] q);
    @(posedge aclk);
    read_en <= 1'b1;
    read_queue <= q;
    @(posedge aclk);
    read_en <= 1'b0;
    #1;
  endtask : drain

  task automatic t_reset;
    reg_rd(`MQW_REG_CTRL);
    chk(rd, 0, "ctrl reset");
    reg_rd(`MQW_REG_IRQ_MASK);
    chk(rd, 0, "mask reset");
    chk(program_done_out_n, 1, "done before setup");
    wr.allow_early = 1'b1;
    wr.step(1, 6'o01, 0, 1, 0);
    wr.step(0, 0, 0, 1, 0);
    wr.allow_early = 1'b0;
    reg_rd(`MQW_REG_STATE);
    chk(rd[3], 0, "early select taken");
    reg_rd(`MQW_REG_IRQ_STAT);
    chk(rd, 1, "refused event");
    chk(irq, 0, "irq while masked");
    reg_wr(`MQW_REG_IRQ_MASK, 7);
    #1 chk(irq, 1, "irq unmasked");
    reg_wr(`MQW_REG_IRQ_STAT, 1);
    #1 chk(irq, 0, "irq cleared");
    reg_wr(8'h20, 0);
    chk(rs, `MQW_RESP_SLVERR, "unmapped write");
    reg_rd(8'h20);
    chk(rs, `MQW_RESP_SLVERR, "unmapped read");
  endtask : t_reset

  task automatic t_select;
    @(posedge aclk);
    program_ready <= 1'b1;
    repeat (3) @(posedge aclk);
    #1 chk(program_done_out_n, 0, "setup done");
    wr.step(1, 6'o00, 0, 1, 0);
    wr.step(0, 0, 0, 1, 0);
    wr.step(1, 6'o02, 0, 0, 36'ha1);
    wr.step(0, 0, 0, 0, 36'hb2);
    wr.step(0, 0, 0, 0, 36'hc3);
    wr.step(0, 0, 0, 1, 0);
    reg_rd(`MQW_REG_STATE);
    chk(rd, 32'h2a, "state after select");
    drain(0);
    chk(read_data, 36'ha1, "old queue on select edge");
    drain(0);
    chk(read_data, 36'hb2, "old queue next edge");
    drain(2);
    chk(read_data, 36'hc3, "new queue second edge");
  endtask : t_select

  task automatic t_device;
    wr.step(1, 6'o13, 0, 0, 36'hd4);
    wr.step(0, 0, 0, 0, 36'he5);
    wr.step(0, 0, 0, 0, 36'hf6);
    wr.step(0, 0, 0, 1, 0);
    reg_rd(`MQW_REG_STATE);
    chk(rd[3], 0, "foreign device valid");
    drain(2);
    chk(read_data, 36'hd4, "prior queue kept");
    drain(2);
    chk(read_data, 36'he5, "prior queue kept");
  endtask : t_device

  task automatic t_full;
    wr.step(1, 6'o03, 0, 1, 0);
    wr.step(0, 0, 0, 1, 0);
    for (int i = 0; i < 5; i++) begin
      wr.step(0, 0, 0, 0, 36'h100 + 36'(i));
      wr.step(0, 0, 0, 1, 0);
      repeat (2) @(posedge aclk);
      #1 chk(almost_full_flag, 36'(i >= 2), "almost full");
      chk(full_flag, 36'(i >= 3), "full");
      reg_rd(`MQW_REG_IRQ_STAT);
      chk(rd, (i == 4) ? 2 : 0, "overrun event");
    end
    reg_rd(`MQW_REG_FLAGS);
    chk(rd, 32'h0808, "flags reg");
    #1 chk(irq, 1, "overrun irq");
    reg_wr(`MQW_REG_IRQ_STAT, 2);
    drain(3);
    chk(read_data, 36'h100, "first stored word");
  endtask : t_full

  task automatic t_direct;
    wr.step(0, 6'o05, 1, 1, 0);
    wr.step(0, 0, 0, 1, 0);
    #1 chk(almost_full_flag_bus_oe, 1, "bus chosen");
    chk(flag_expansion_out, 0, "expansion delay");
    @(posedge aclk);
    #1 chk(flag_expansion_out, 1, "expansion out");
    chk(almost_full_flag_bus[3], 1, "bus status");
    @(posedge aclk);
    flag_expansion_in <= 1'b1;
    @(posedge aclk);
    flag_expansion_in <= 1'b0;
    reg_rd(`MQW_REG_IRQ_STAT);
    chk(rd, 4, "contention event");
    reg_wr(`MQW_REG_IRQ_STAT, 4);
    wr.step(0, 6'o20, 1, 1, 0);
    wr.step(0, 0, 0, 1, 0);
    #1 chk(almost_full_flag_bus_oe, 0, "bus released");
  endtask : t_direct

  task automatic t_polled;
    reg_wr(`MQW_REG_CTRL, 32'h5);
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      #1 sv[i] = flag_bus_sync;
      ov[i] = almost_full_flag_bus_oe;
    end
    chk(sv, {sv[7:0], sv[15:8]}, "sync period");
    chk($countones(sv), 2, "sync count");
    chk(ov, {sv[13:0], sv[15:14]}, "poll slot");
  endtask : t_polled

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // Whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      $display("[FAIL] %0t run did not finish in time", $time);
      mismatches++;
      finish_test();
    end
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {program_ready, read_en, flag_expansion_in} = '0;
    read_queue = 3'h0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_select();
    t_device();
    t_full();
    t_direct();
    t_polled();
    finish_test();
  end
endmodule : tb
`default_nettype wire
